//--- verilog/ehist_pkg.sv
// ehist_pkg: constants and carrier types of the interrupt status and enable block
// assumes one core clock; register offsets are byte offsets in the operational space
package ehist_pkg;
	localparam logic [7:0]  OFS_STATUS    = 8'h24;
	localparam logic [7:0]  OFS_ENABLE    = 8'h28;
	localparam int          FLAG_W        = 6;
	localparam int          BIT_ASYNC     = 5;
	localparam int          BIT_SYSERR    = 4;
	localparam int          BIT_ROLL      = 3;
	localparam int          BIT_PORT      = 2;
	localparam int          BIT_TERR      = 1;
	localparam int          BIT_TDONE     = 0;
	localparam int          IDX_BIT_1024  = 13;
	localparam int          IDX_BIT_512   = 12;
	localparam logic [1:0]  FLS_1024      = 2'h0;
	localparam logic [1:0]  FLS_512       = 2'h1;
	localparam logic [5:0]  ENABLE_RESET  = 6'h00;
	localparam logic [5:0]  STATUS_RESET  = 6'h00;
	localparam logic [5:0]  THRESH_MASK   = 6'h23;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} ehist_bus_t;

	typedef struct packed {
		logic        doorbell;
		logic        async_adv;
		logic        parity_err;
		logic        master_abort;
		logic        target_abort;
		logic [1:0]  frame_list_size;
		logic [13:0] frame_index;
		logic        port_chg;
		logic        force_resume;
		logic        d3_to_d0;
		logic        port_chg_or;
		logic        td_retire;
		logic        td_error;
		logic        td_ioc;
		logic        short_pkt;
		logic        threshold;
	} ehist_evt_t;
endpackage : ehist_pkg

//--- verilog/ehist_edge.sv
// ehist_edge: rising and toggle detector for a group of event levels
// assumes inputs already in the core clock domain
`timescale 1ns/1ns
module ehist_edge #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] lvl,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] tog
);
	typedef struct packed {
		logic [W-1:0] prev;
	} ehist_edge_st_t;
	ehist_edge_st_t st_r;
	ehist_edge_st_t st_nxt;

	always_comb begin
		st_nxt.prev = lvl;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rise = lvl & ~st_r.prev;
	assign tog  = lvl ^ st_r.prev;
endmodule : ehist_edge

//--- verilog/ehist_top.sv
// ehist_top: interrupt status and enable registers with interrupt generation
// assumes a register port on the core clock, event inputs on the core clock
`timescale 1ns/1ns
module ehist_top (
	input  wire logic                  CORE_CLK,
	input  wire logic                  NRST,
	input  wire ehist_pkg::ehist_bus_t BUS,
	input  wire ehist_pkg::ehist_evt_t EVT,
	output logic [31:0]                RDATA,
	output logic                       IRQ,
	output logic                       RUN_STOP_CLR,
	output logic [5:0]                 STATUS,
	output logic [5:0]                 ENABLE
);
	typedef struct packed {
		logic        armed;
		logic [5:0]  status;
		logic [5:0]  enable;
		logic [5:0]  pending;
		logic [31:0] rdata;
		logic        irq;
		logic        rs_clr;
		logic        idx_init;
	} ehist_st_t;

	ehist_st_t  st_r;
	ehist_st_t  st_nxt;
	logic [2:0] rise;
	logic [2:0] tog;
	logic [5:0] set_v;
	logic       idx_tog;

	ehist_edge #(.W(3)) u_edge (
		.clk  (CORE_CLK),
		.nrst (NRST),
		.lvl  ({EVT.port_chg | EVT.force_resume,
			EVT.frame_index[ehist_pkg::IDX_BIT_1024],
			EVT.frame_index[ehist_pkg::IDX_BIT_512]}),
		.rise (rise),
		.tog  (tog)
	);

	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction : is_addr

	always_comb begin
		st_nxt = st_r;
		set_v  = 6'h00;
		idx_tog = (EVT.frame_list_size == ehist_pkg::FLS_512) ? tog[0] : tog[1];
		if (EVT.doorbell) begin
			st_nxt.armed = 1'b1;
		end
		if (st_r.armed && EVT.async_adv) begin
			set_v[ehist_pkg::BIT_ASYNC] = 1'b1;
			st_nxt.armed = EVT.doorbell;
		end
		set_v[ehist_pkg::BIT_SYSERR] = EVT.parity_err | EVT.master_abort | EVT.target_abort;
		set_v[ehist_pkg::BIT_ROLL] = idx_tog & st_r.idx_init;
		set_v[ehist_pkg::BIT_PORT] = rise[2] | (EVT.d3_to_d0 & EVT.port_chg_or);
		set_v[ehist_pkg::BIT_TERR] = EVT.td_error;
		set_v[ehist_pkg::BIT_TDONE] = (EVT.td_retire & EVT.td_ioc)
			| (EVT.td_error & EVT.td_ioc)
			| EVT.short_pkt;
		st_nxt.idx_init = 1'b1;
		st_nxt.rs_clr = set_v[ehist_pkg::BIT_SYSERR];
		if (BUS.wr && is_addr(BUS.addr, ehist_pkg::OFS_STATUS)) begin
			st_nxt.status = st_r.status & ~BUS.wdata[5:0];
		end
		if (BUS.wr && is_addr(BUS.addr, ehist_pkg::OFS_ENABLE)) begin
			st_nxt.enable = BUS.wdata[5:0];
		end
		st_nxt.status = st_nxt.status | set_v;
		// threshold sources wait, others pass immediately
		st_nxt.pending = st_r.pending & st_nxt.status;
		if (EVT.threshold) begin
			st_nxt.pending = st_nxt.status & ehist_pkg::THRESH_MASK;
		end
		st_nxt.irq = |(st_nxt.enable & ((st_nxt.status & ~ehist_pkg::THRESH_MASK)
			| (st_nxt.pending & ehist_pkg::THRESH_MASK)));
		st_nxt.rdata = 32'h0000_0000;
		if (BUS.rd && is_addr(BUS.addr, ehist_pkg::OFS_STATUS)) begin
			st_nxt.rdata = {26'h0, st_r.status};
		end else if (BUS.rd && is_addr(BUS.addr, ehist_pkg::OFS_ENABLE)) begin
			st_nxt.rdata = {26'h0, st_r.enable};
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			st_r        <= '0;
			st_r.status <= ehist_pkg::STATUS_RESET;
			st_r.enable <= ehist_pkg::ENABLE_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign RDATA        = st_r.rdata;
	assign IRQ          = st_r.irq;
	assign RUN_STOP_CLR = st_r.rs_clr;
	assign STATUS       = st_r.status;
	assign ENABLE       = st_r.enable;

	sequence door_armed_s;
		EVT.doorbell ##1 !EVT.async_adv;
	endsequence

	sequence door_then_adv_s;
		door_armed_s ##1 EVT.async_adv;
	endsequence

	async_flag_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		door_then_adv_s |=> STATUS[ehist_pkg::BIT_ASYNC])
		else $error("async advance flag not set");
	syserr_flag_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		EVT.master_abort |=> STATUS[ehist_pkg::BIT_SYSERR])
		else $error("system error flag not set");
	run_stop_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(EVT.parity_err || EVT.target_abort) |=> RUN_STOP_CLR)
		else $error("run stop not cleared");
	port_flag_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		$rose(EVT.port_chg || EVT.force_resume) |=> STATUS[ehist_pkg::BIT_PORT])
		else $error("port change flag not set");
	terr_both_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(EVT.td_error && EVT.td_ioc) |=> STATUS[1:0] == 2'h3)
		else $error("error with completion not both set");
	short_pkt_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		EVT.short_pkt |=> STATUS[ehist_pkg::BIT_TDONE])
		else $error("short packet flag missing");
	irq_gate_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		IRQ |-> (|(STATUS & ENABLE)))
		else $error("interrupt without enabled flag");
	w1c_clear_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(BUS.wr && BUS.addr == ehist_pkg::OFS_STATUS && BUS.wdata[3]
			&& !tog[0] && !tog[1]) |=> !STATUS[ehist_pkg::BIT_ROLL])
		else $error("write one did not clear flag");
	enable_wr_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(BUS.wr && BUS.addr == ehist_pkg::OFS_ENABLE) |=> ENABLE == $past(BUS.wdata[5:0]))
		else $error("enable register not written");
	syserr_irq_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(STATUS[ehist_pkg::BIT_SYSERR] && ENABLE[ehist_pkg::BIT_SYSERR]
			&& !BUS.wr) |=> IRQ)
		else $error("system error interrupt delayed");
	parity_flag_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		EVT.parity_err |=> STATUS[ehist_pkg::BIT_SYSERR])
		else $error("parity error did not set system error flag");
	target_flag_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		EVT.target_abort |=> STATUS[ehist_pkg::BIT_SYSERR])
		else $error("target abort did not set system error flag");
	syserr_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(!EVT.parity_err && !EVT.master_abort && !EVT.target_abort && !BUS.wr
			&& !STATUS[ehist_pkg::BIT_SYSERR]) |=> !STATUS[ehist_pkg::BIT_SYSERR])
		else $error("system error flag set without a bus error");
	run_abort_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		EVT.master_abort |=> RUN_STOP_CLR)
		else $error("run stop not cleared on master abort");
	run_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(!EVT.parity_err && !EVT.master_abort && !EVT.target_abort) |=> !RUN_STOP_CLR)
		else $error("run stop cleared without a bus error");
	roll_long_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(EVT.frame_list_size != ehist_pkg::FLS_512 && $past(NRST)
			&& $changed(EVT.frame_index[ehist_pkg::IDX_BIT_1024]))
			|=> STATUS[ehist_pkg::BIT_ROLL])
		else $error("rollover flag missed on long frame list");
	roll_short_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(EVT.frame_list_size == ehist_pkg::FLS_512 && $past(NRST)
			&& $changed(EVT.frame_index[ehist_pkg::IDX_BIT_512]))
			|=> STATUS[ehist_pkg::BIT_ROLL])
		else $error("rollover flag missed on short frame list");
	roll_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(!$changed(EVT.frame_index[ehist_pkg::IDX_BIT_1024])
			&& !$changed(EVT.frame_index[ehist_pkg::IDX_BIT_512])
			&& !BUS.wr && !STATUS[ehist_pkg::BIT_ROLL]) |=> !STATUS[ehist_pkg::BIT_ROLL])
		else $error("rollover flag set without index wrap");
	port_load_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(EVT.d3_to_d0 && EVT.port_chg_or) |=> STATUS[ehist_pkg::BIT_PORT])
		else $error("port change flag not loaded on power up");
	port_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(!$rose(EVT.port_chg || EVT.force_resume) && !EVT.d3_to_d0 && !BUS.wr
			&& !STATUS[ehist_pkg::BIT_PORT]) |=> !STATUS[ehist_pkg::BIT_PORT])
		else $error("port change flag set without a port event");
	terr_flag_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		EVT.td_error |=> STATUS[ehist_pkg::BIT_TERR])
		else $error("transaction error flag not set");
	terr_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(!EVT.td_error && !BUS.wr && !STATUS[ehist_pkg::BIT_TERR])
			|=> !STATUS[ehist_pkg::BIT_TERR])
		else $error("transaction error flag set without an error");
	masked_set_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(EVT.td_error && ENABLE == 6'h00) |=> STATUS[ehist_pkg::BIT_TERR])
		else $error("disabled source did not set its flag");
	tdone_flag_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(EVT.td_retire && EVT.td_ioc) |=> STATUS[ehist_pkg::BIT_TDONE])
		else $error("completion flag not set on retire");
	tdone_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(!EVT.td_ioc && !EVT.short_pkt && !BUS.wr && !STATUS[ehist_pkg::BIT_TDONE])
			|=> !STATUS[ehist_pkg::BIT_TDONE])
		else $error("completion flag set without a cause");
	async_quiet_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(!EVT.async_adv && !BUS.wr && !STATUS[ehist_pkg::BIT_ASYNC])
			|=> !STATUS[ehist_pkg::BIT_ASYNC])
		else $error("async advance flag set without an advance");
	flag_hold_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		!(BUS.wr && BUS.addr == ehist_pkg::OFS_STATUS)
			|=> ((STATUS & $past(STATUS)) == $past(STATUS)))
		else $error("status flag cleared without a write");
	irq_now_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(|(STATUS & ENABLE & ~ehist_pkg::THRESH_MASK) && !BUS.wr) |=> IRQ)
		else $error("immediate source interrupt delayed");
	irq_thresh_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(EVT.threshold && !BUS.wr && |(STATUS & ENABLE)) |=> IRQ)
		else $error("interrupt missing at threshold");
	irq_wait_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(!IRQ && !EVT.threshold && !BUS.wr
			&& ((STATUS | set_v) & ENABLE & ~ehist_pkg::THRESH_MASK) == 6'h00) |=> !IRQ)
		else $error("threshold source interrupt before threshold");
	irq_hold_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(IRQ && !BUS.wr) |=> IRQ)
		else $error("interrupt dropped before acknowledge");
	irq_drop_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(BUS.wr && BUS.addr == ehist_pkg::OFS_ENABLE && BUS.wdata[5:0] == 6'h00)
			|=> !IRQ)
		else $error("interrupt with all sources disabled");
	enable_keep_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		!(BUS.wr && BUS.addr == ehist_pkg::OFS_ENABLE) |=> $stable(ENABLE))
		else $error("enable register changed without a write");
	rdata_idle_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		!BUS.rd |=> RDATA == 32'h0000_0000)
		else $error("read data not zero without a read");
	rdata_status_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(BUS.rd && BUS.addr == ehist_pkg::OFS_STATUS) |=> RDATA == {26'h0, $past(STATUS)})
		else $error("status read returned wrong value");
	rdata_enable_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
		(BUS.rd && BUS.addr == ehist_pkg::OFS_ENABLE) |=> RDATA == {26'h0, $past(ENABLE)})
		else $error("enable read returned wrong value");
endmodule : ehist_top

//--- verif/tb_top.sv
// tb_top: self-checking bench with a behavioural model of the status and enable block
// assumes ehist_pkg and ehist_top are compiled first; the bench drives every port itself
`timescale 1ns/1ns
module tb_top;
	logic                  clk = 1'b0;
	logic                  nrst = 1'b0;
	ehist_pkg::ehist_bus_t bs = '0;
	ehist_pkg::ehist_evt_t ev = '0;
	ehist_pkg::ehist_evt_t e;
	ehist_pkg::ehist_bus_t b;
	ehist_pkg::ehist_evt_t lvl = '{frame_list_size: 2'h3, frame_index: 14'h3FFF,
		port_chg: 1'b1, force_resume: 1'b1, port_chg_or: 1'b1, default: 1'b0};
	logic [31:0]           rdata;
	logic                  irq;
	logic                  rsc;
	logic [5:0]            sts;
	logic [5:0]            ena;
	logic [5:0]            s;
	logic [5:0]            en;
	logic [5:0]            pd;
	logic                  arm;
	logic [31:0]           x = 32'h0001669D;
	logic [31:0]           r;
	int                    err_count = 0;
	int                    comparisons = 0;
	always #5 clk = ~clk;
	ehist_top ehist_top_inst (.CORE_CLK(clk), .NRST(nrst), .BUS(bs), .EVT(ev), .RDATA(rdata),
		.IRQ(irq), .RUN_STOP_CLR(rsc), .STATUS(sts), .ENABLE(ena));
	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : rnd
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic do_reset();
		nrst = 1'b0;
		bs = '0;
		ev = '0;
		s = 6'h00;
		en = 6'h00;
		pd = 6'h00;
		arm = 1'b0;
		repeat (5) @(posedge clk);
		#1 nrst = 1'b1;
		chk(sts === 6'h00 && ena === 6'h00 && irq === 1'b0, "reset values");
	endtask : do_reset
	task automatic op(input ehist_pkg::ehist_evt_t e, input ehist_pkg::ehist_bus_t b);
		logic [5:0]  sn;
		logic [31:0] er;
		logic        roll;
		sn = s;
		er = 32'h0;
		if (b.rd && b.addr == ehist_pkg::OFS_STATUS) er = {26'h0, s};
		if (b.rd && b.addr == ehist_pkg::OFS_ENABLE) er = {26'h0, en};
		if (b.wr && b.addr == ehist_pkg::OFS_STATUS) sn = sn & ~b.wdata[5:0];
		if (b.wr && b.addr == ehist_pkg::OFS_ENABLE) en = b.wdata[5:0];
		if (arm && e.async_adv) sn[5] = 1'b1;
		if (e.async_adv) arm = 1'b0;
		if (e.doorbell) arm = 1'b1;
		if (e.parity_err | e.master_abort | e.target_abort) sn[4] = 1'b1;
		roll = (e.frame_list_size == ehist_pkg::FLS_512) ?
			(ev.frame_index[12] != e.frame_index[12]) : (ev.frame_index[13] != e.frame_index[13]);
		if (roll) sn[3] = 1'b1;
		if (((e.port_chg | e.force_resume) && !(ev.port_chg | ev.force_resume))
			|| (e.d3_to_d0 && e.port_chg_or)) sn[2] = 1'b1;
		if (e.td_error) sn[1] = 1'b1;
		if ((e.td_ioc && (e.td_error || e.td_retire)) || e.short_pkt) sn[0] = 1'b1;
		if (e.threshold) pd = sn;
		s = sn;
		pd = pd & s & ehist_pkg::THRESH_MASK;
		@(posedge clk);
		#1 ev = e;
		bs = b;
		@(posedge clk);
		#1 ev = e & lvl;
		bs = '0;
		chk(sts === s, "status flags");
		chk(ena === en, "enable register");
		chk(irq === |(s & en & (~ehist_pkg::THRESH_MASK | pd)), "interrupt");
		chk(rsc === (e.parity_err | e.master_abort | e.target_abort), "run stop clear");
		chk(rdata === er, "read data");
	endtask : op
	initial begin
		do_reset();
		e = '0;
		e.doorbell = 1'b1;
		op(e, '0);
		e.doorbell = 1'b0;
		e.async_adv = 1'b1;
		op(e, '0);
		for (int i = 0; i < 600; i++) begin
			if (i == 300) do_reset();
			e = ev;
			b = '0;
			r = rnd();
			e.threshold = (r[31:30] == 2'h0);
			case (r[3:0])
				4'h0: e.doorbell = 1'b1;
				4'h1: e.async_adv = 1'b1;
				4'h2: e.parity_err = 1'b1;
				4'h3: e.master_abort = 1'b1;
				4'h4: e.target_abort = 1'b1;
				4'h5: e.frame_index ^= 14'h1000;
				4'h6: e.frame_index ^= 14'h2000;
				4'h7: e.port_chg = ~e.port_chg;
				4'h8: {e.d3_to_d0, e.port_chg_or} = 2'h3;
				4'h9: {e.td_error, e.td_ioc} = {1'b1, r[4]};
				4'hA: {e.td_retire, e.td_ioc} = {1'b1, r[4]};
				4'hB: e.short_pkt = 1'b1;
				4'hC: e.frame_list_size = {1'b0, r[5]};
				4'hD: e.force_resume = ~e.force_resume;
				default: ;
			endcase
			case (r[10:8])
				3'h0: b = '{wr: 1'b1, rd: 1'b0, addr: ehist_pkg::OFS_STATUS, wdata: rnd()};
				3'h1: b = '{wr: 1'b1, rd: 1'b0, addr: ehist_pkg::OFS_ENABLE, wdata: rnd()};
				3'h2: b = '{wr: 1'b0, rd: 1'b1, addr: ehist_pkg::OFS_STATUS, wdata: 32'h0};
				3'h3: b = '{wr: 1'b0, rd: 1'b1, addr: ehist_pkg::OFS_ENABLE, wdata: 32'h0};
				3'h4: b = '{wr: 1'b0, rd: 1'b1, addr: r[23:16], wdata: 32'h0};
				3'h5: b = '{wr: 1'b1, rd: 1'b0, addr: r[23:16], wdata: rnd()};
				default: ;
			endcase
			op(e, b);
		end
		print_verdict();
	end
	initial begin
		#100000;
		err_count++;
		print_verdict();
	end
endmodule : tb_top
